//--- shared/pct_regs.svh
/*
 Constants of the programmable cam arc timer: register offsets, fields, limits and timing.
 Assumes a 40 MHz system clock and a resolver that reports whole degrees.
*/
`ifndef PCT_REGS_SVH
`define PCT_REGS_SVH

// Register byte offsets
`define PCT_REG_SEL 8'h00
`define PCT_REG_ANG 8'h04
`define PCT_REG_CMD 8'h08
`define PCT_REG_DWELL 8'h0C
`define PCT_REG_BATCH 8'h10
`define PCT_REG_GLOBAL 8'h14
`define PCT_REG_POS 8'h18
`define PCT_REG_STATUS 8'h1C
`define PCT_REG_OUT 8'h20

// Command bits
`define PCT_CMD_ADD 0
`define PCT_CMD_CLR 1
`define PCT_CMD_TIMED 2
`define PCT_CMD_ARCS 3

// Field positions
`define PCT_ANG_OFF_LSB 16
`define PCT_ST_TIMED_LSB 8
`define PCT_ST_REJ 16

// Limits
`define PCT_NCH 16
`define PCT_NARC 3'h4
`define PCT_XPOOL 6'h06
`define PCT_NTIMED 5'h04
`define PCT_ANG_MAX 9'h167
`define PCT_BATCH_CH0 5
`define PCT_NBATCH 3

// Timing
`define PCT_DWELL_MAX_MS 500
`define PCT_DWELL_STEP_MS 10
`define PCT_DWELL_MAX_STEP 6'(`PCT_DWELL_MAX_MS / `PCT_DWELL_STEP_MS)
`define PCT_CLK_KHZ 40000
`define PCT_TICK_MS 1
`define PCT_MS_CYC (`PCT_CLK_KHZ * `PCT_TICK_MS)

`endif

//--- shared/pct_pkg.sv
/*
 Types of the programmable cam arc timer.
 Assumes nothing beyond a SystemVerilog elaborator.
*/
package pct_pkg;
   // Channel program type
   typedef enum logic {
      PCT_MODE_ARCS = 1'b0,
      PCT_MODE_TIMED = 1'b1
   } pct_mode_t;

   // One on/off arc in whole degrees
   typedef struct packed {
      logic [8:0] off;
      logic [8:0] on;
   } pct_arc_t;
endpackage : pct_pkg

//--- rtl/pct_cam_timer.sv
/*
 Programmable cam switch: sixteen channels driven from crank angle, by arcs or by timed dwell.
 Assumes the resolver angle arrives asynchronously and stays stable while it is sampled,
 and that software reaches the registers over a simple strobe port on clk.
*/
// The strobed register port and the address map were decided locally.
`timescale 1ns/100ps
`include "pct_regs.svh"

module pct_cam_timer #(
   parameter int unsigned MS_CYCLES = `PCT_MS_CYC
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [8:0] angle_pin,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic [15:0] cam_out
);

   // True when angle a lies in arc r; on equal to off gives an empty arc
   function automatic logic in_arc(input logic [8:0] a, input pct_pkg::pct_arc_t r);
      if (r.on <= r.off) begin
         return (a >= r.on) && (a < r.off);
      end
      return (a >= r.on) || (a < r.off);
   endfunction : in_arc

   // True when the crank moved from p to c passing the on angle
   function automatic logic crossed(input logic [8:0] p, input logic [8:0] c, input logic [8:0] on);
      if (p == c) begin
         return 1'b0;
      end
      if (p < c) begin
         return (on > p) && (on <= c);
      end
      return (on > p) || (on <= c);
   endfunction : crossed

   // Out-of-range angles are held at the last whole degree
   function automatic logic [8:0] clamp_ang(input logic [8:0] a);
      return (a > `PCT_ANG_MAX) ? `PCT_ANG_MAX : a;
   endfunction : clamp_ang

   logic [8:0] ang_meta;
   logic [8:0] ang_raw;
   // Clamp sits after the second flop so no logic ever sees a settling bit
   wire [8:0] ang_now = clamp_ang(ang_raw);
   logic [8:0] ang_prev;
   pct_pkg::pct_arc_t arc [`PCT_NCH][4];
   logic [2:0] cnt [`PCT_NCH];
   pct_pkg::pct_mode_t mode [`PCT_NCH];
   logic [5:0] dwell [`PCT_NCH];
   logic [9:0] rem [`PCT_NCH];
   logic [3:0] sel_ch;
   logic [1:0] sel_arc;
   logic [2:0] batch_use;
   logic [15:0] global_ch;
   logic rejected;
   logic [15:0] ms_cnt;
   logic ms_tick;
   logic [5:0] extra_used;
   logic [4:0] timed_used;
   logic [15:0] fire;
   logic [15:0] next_cam;
   logic [31:0] rd_val;

   // Resolver angle synchroniser; only the second flop feeds logic
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ang_meta <= 9'h000;
         ang_raw <= 9'h000;
         ang_prev <= 9'h000;
      end else begin
         ang_meta <= angle_pin;
         ang_raw <= ang_meta;
         ang_prev <= ang_now;
      end
   end

   // Register decode
   wire wr_sel = reg_wr && (reg_addr == `PCT_REG_SEL);
   wire wr_ang = reg_wr && (reg_addr == `PCT_REG_ANG);
   wire wr_cmd = reg_wr && (reg_addr == `PCT_REG_CMD);
   wire wr_dwell = reg_wr && (reg_addr == `PCT_REG_DWELL);
   wire wr_batch = reg_wr && (reg_addr == `PCT_REG_BATCH);
   wire wr_global = reg_wr && (reg_addr == `PCT_REG_GLOBAL);
   wire wr_status = reg_wr && (reg_addr == `PCT_REG_STATUS);
   wire [2:0] cnt_sel = cnt[sel_ch];
   wire pct_pkg::pct_arc_t arc_sel = arc[sel_ch][sel_arc];
   wire [3:0] wr_ch = reg_wdata[3:0];
   wire [2:0] wr_arc = {1'b0, reg_wdata[5:4]};

   // Command qualification; a refused command changes nothing but the sticky flag
   wire add_go = wr_cmd && reg_wdata[`PCT_CMD_ADD];
   wire add_ok = add_go && (cnt_sel < `PCT_NARC) && ((cnt_sel == 3'h0) || (extra_used < `PCT_XPOOL));
   wire clr_go = wr_cmd && reg_wdata[`PCT_CMD_CLR];
   wire timed_go = wr_cmd && reg_wdata[`PCT_CMD_TIMED];
   wire timed_ok = timed_go && ((mode[sel_ch] == pct_pkg::PCT_MODE_TIMED) || global_ch[sel_ch]
                                || (timed_used < `PCT_NTIMED));
   wire arcs_go = wr_cmd && reg_wdata[`PCT_CMD_ARCS];
   wire rej_go = (add_go && !add_ok) || (timed_go && !timed_ok);
   wire [5:0] dwell_in = (reg_wdata[5:0] > `PCT_DWELL_MAX_STEP) ? `PCT_DWELL_MAX_STEP : reg_wdata[5:0];

   // Batch counters one to three own channels six to eight
   wire [15:0] batch_mask = 16'(batch_use) << `PCT_BATCH_CH0;

   // Pool usage: every channel counts toward the extra arc pool, global or not; global channels stay out of the timed count
   always_comb begin
      extra_used = 6'h00;
      timed_used = 5'h00;
      for (int i = 0; i < `PCT_NCH; i++) begin
         if (cnt[i] > 3'h1) begin
            extra_used = extra_used + 6'(cnt[i] - 3'h1);
         end
         if ((mode[i] == pct_pkg::PCT_MODE_TIMED) && !global_ch[i]) begin
            timed_used = timed_used + 5'h01;
         end
      end
   end

   // Channel program store; clearing is the only way arcs ever go away
   always_ff @(posedge clk) begin
      if (!resetn) begin
         for (int i = 0; i < `PCT_NCH; i++) begin
            cnt[i] <= 3'h0;
            mode[i] <= pct_pkg::PCT_MODE_ARCS;
            dwell[i] <= 6'h00;
            for (int j = 0; j < 4; j++) begin
               arc[i][j] <= '0;
            end
         end
         sel_ch <= 4'h0;
         sel_arc <= 2'h0;
      end else if (clr_go) begin
         cnt[sel_ch] <= 3'h0;
         mode[sel_ch] <= pct_pkg::PCT_MODE_ARCS;
         dwell[sel_ch] <= 6'h00;
         for (int j = 0; j < 4; j++) begin
            arc[sel_ch][j] <= '0;
         end
         sel_arc <= 2'h0;
      end else begin
         if (wr_sel) begin
            sel_ch <= wr_ch;
            sel_arc <= (wr_arc < cnt[wr_ch]) ? wr_arc[1:0] : 2'h0;
         end
         if (add_ok) begin
            cnt[sel_ch] <= cnt_sel + 3'h1;
            arc[sel_ch][cnt_sel[1:0]] <= '0;
            sel_arc <= cnt_sel[1:0];
         end
         if (wr_ang) begin
            arc[sel_ch][sel_arc].on <= clamp_ang(reg_wdata[8:0]);
            arc[sel_ch][sel_arc].off <= clamp_ang(reg_wdata[`PCT_ANG_OFF_LSB +: 9]);
            if (cnt_sel == 3'h0) begin
               cnt[sel_ch] <= 3'h1;
            end
         end
         if (timed_ok) begin
            mode[sel_ch] <= pct_pkg::PCT_MODE_TIMED;
         end
         if (arcs_go) begin
            mode[sel_ch] <= pct_pkg::PCT_MODE_ARCS;
         end
         if (wr_dwell) begin
            dwell[sel_ch] <= dwell_in;
         end
      end
   end

   // Side registers; a refusal in the same cycle as the clear keeps the flag set
   always_ff @(posedge clk) begin
      if (!resetn) begin
         batch_use <= 3'h0;
         global_ch <= 16'h0000;
         rejected <= 1'b0;
      end else begin
         if (wr_batch) begin
            batch_use <= reg_wdata[2:0];
         end
         if (wr_global) begin
            global_ch <= reg_wdata[15:0];
         end
         if (rej_go) begin
            rejected <= 1'b1;
         end else if (wr_status && reg_wdata[`PCT_ST_REJ]) begin
            rejected <= 1'b0;
         end
      end
   end

   // Millisecond tick; the first tick of a dwell may come early by up to one ms
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ms_cnt <= 16'h0000;
         ms_tick <= 1'b0;
      end else begin
         ms_tick <= (ms_cnt == 16'(MS_CYCLES - 1));
         ms_cnt <= (ms_cnt == 16'(MS_CYCLES - 1)) ? 16'h0000 : ms_cnt + 16'h0001;
      end
   end

   // Output evaluation from current angle and dwell timers
   always_comb begin
      next_cam = 16'h0000;
      fire = 16'h0000;
      for (int i = 0; i < `PCT_NCH; i++) begin
         fire[i] = (mode[i] == pct_pkg::PCT_MODE_TIMED) && crossed(ang_prev, ang_now, arc[i][0].on);
         if (mode[i] == pct_pkg::PCT_MODE_TIMED) begin
            next_cam[i] = (rem[i] != 10'h000);
         end else begin
            for (int j = 0; j < 4; j++) begin
               if ((3'(j) < cnt[i]) && in_arc(ang_now, arc[i][j])) begin
                  next_cam[i] = 1'b1;
               end
            end
         end
         // Batch ownership overrides both modes
         if (batch_mask[i]) begin
            next_cam[i] = 1'b0;
         end
      end
   end

   // Dwell timers run on ticks alone, so a stopped crank cannot hold them on
   always_ff @(posedge clk) begin
      if (!resetn) begin
         for (int i = 0; i < `PCT_NCH; i++) begin
            rem[i] <= 10'h000;
         end
      end else begin
         for (int i = 0; i < `PCT_NCH; i++) begin
            if (clr_go && (sel_ch == 4'(i))) begin
               rem[i] <= 10'h000;
            end else if (fire[i]) begin
               rem[i] <= 10'(dwell[i]) * 10'(`PCT_DWELL_STEP_MS);
            end else if (ms_tick && (rem[i] != 10'h000)) begin
               rem[i] <= rem[i] - 10'h001;
            end
         end
      end
   end

   // Read mux; unmapped offsets read zero
   always_comb begin
      unique case (reg_addr)
         `PCT_REG_SEL: rd_val = {26'h000_0000, sel_arc, sel_ch};
         `PCT_REG_ANG: rd_val = {7'h00, arc_sel.off, 7'h00, arc_sel.on};
         `PCT_REG_CMD: rd_val = {27'h000_0000, cnt_sel, 1'b0, mode[sel_ch]};
         `PCT_REG_DWELL: rd_val = {26'h000_0000, dwell[sel_ch]};
         `PCT_REG_BATCH: rd_val = {29'h000_0000, batch_use};
         `PCT_REG_GLOBAL: rd_val = {16'h0000, global_ch};
         `PCT_REG_POS: rd_val = {23'h00_0000, ang_now};
         `PCT_REG_STATUS: rd_val = {15'h0000, rejected, 3'h0, timed_used, 2'h0, extra_used};
         `PCT_REG_OUT: rd_val = {16'h0000, cam_out};
         default: rd_val = 32'h0000_0000;
      endcase
   end

   // Outputs straight from flops; read data stands for one cycle only
   always_ff @(posedge clk) begin
      if (!resetn) begin
         reg_rdata <= 32'h0000_0000;
         cam_out <= 16'h0000;
      end else begin
         reg_rdata <= reg_rd ? rd_val : 32'h0000_0000;
         cam_out <= next_cam;
      end
   end

   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   logic cnt_over;
   logic dwell_over;
   always_comb begin
      cnt_over = 1'b0;
      dwell_over = 1'b0;
      for (int i = 0; i < `PCT_NCH; i++) begin
         cnt_over = cnt_over || (cnt[i] > `PCT_NARC);
         dwell_over = dwell_over || (rem[i] > 10'(`PCT_DWELL_MAX_MS));
      end
   end
   wire hit0 = (mode[0] == pct_pkg::PCT_MODE_ARCS) && (cnt[0] != 3'h0) && in_arc(ang_now, arc[0][0]);

   AST_ARC_LIMIT: assert property (!cnt_over)
      else $error("channel holds more than four arcs");
   AST_POOL: assert property (extra_used <= `PCT_XPOOL)
      else $error("extra arc pool exceeded");
   // Refusals leave the channel untouched; a clear in the same write wins over all
   AST_ADD_REFUSED: assert property (add_go && !clr_go && (cnt_sel != 3'h0) && (extra_used == `PCT_XPOOL)
                                     |=> rejected && $stable(cnt_sel))
      else $error("add beyond shared pool was taken");
   AST_FIFTH_ARC: assert property (add_go && !clr_go && (cnt_sel == `PCT_NARC)
                                   |=> rejected && (cnt_sel == `PCT_NARC))
      else $error("fifth arc was taken");
   AST_ADD_ZERO: assert property (add_ok && !clr_go |=> (sel_arc == $past(cnt_sel[1:0])) && (arc_sel == '0))
      else $error("new arc not zeroed or not selected");
   AST_NO_SINGLE_REMOVE: assert property ((cnt_sel < $past(cnt_sel)) && (sel_ch == $past(sel_ch))
                                          |-> $past(clr_go))
      else $error("arc count fell without a clear");
   AST_CLEAR_ALL: assert property (clr_go |=> (cnt_sel == 3'h0) && (sel_arc == 2'h0) && (arc_sel == '0)
                                   && (mode[sel_ch] == pct_pkg::PCT_MODE_ARCS) && (dwell[sel_ch] == 6'h00)
                                   && (rem[sel_ch] == 10'h000))
      else $error("clear left a setting behind");
   AST_TIMED_LIMIT: assert property (timed_used <= `PCT_NTIMED)
      else $error("more than four timed channels");
   AST_TIMED_REFUSED: assert property (timed_go && !arcs_go && !clr_go && !global_ch[sel_ch]
                                       && (mode[sel_ch] == pct_pkg::PCT_MODE_ARCS) && (timed_used == `PCT_NTIMED)
                                       |=> rejected && (mode[sel_ch] == pct_pkg::PCT_MODE_ARCS))
      else $error("fifth timed channel was taken");

   // Timer checks for every channel, since any channel may be the timed one
   for (genvar g = 0; g < `PCT_NCH; g++) begin : g_timer_chk
      AST_TIMED_FIRE: assert property (fire[g] && (dwell[g] != 6'h00) && !clr_go && !arcs_go
                                       && !wr_batch && !batch_mask[g] |=> ##1 cam_out[g])
         else $error("timed channel did not switch on");
      AST_TIMED_DECAY: assert property (ms_tick && (rem[g] != 10'h000) && !fire[g] && !clr_go
                                        |=> rem[g] == $past(rem[g]) - 10'h001)
         else $error("dwell timer did not count down");
   end

   AST_DWELL_MAX: assert property (!dwell_over)
      else $error("dwell beyond 500 ms");
   AST_DWELL_CLAMP: assert property (wr_dwell |=> (dwell[sel_ch] <= `PCT_DWELL_MAX_STEP))
      else $error("dwell setting stored beyond its limit");
   AST_ARC_HOLD: assert property (hit0 && $stable(ang_now) |=> cam_out[0])
      else $error("arc channel dropped inside its arc");
   AST_BATCH_OFF: assert property (batch_use[0] |=> !cam_out[`PCT_BATCH_CH0])
      else $error("shared channel on while batch counter used");

   // Main scenarios
   COV_ADD: cover property (add_ok ##2 add_ok);
   COV_REJECT: cover property (rej_go);
   COV_TIMED: cover property ((fire != 16'h0000) ##2 (cam_out != 16'h0000));
   COV_WRAP: cover property (hit0 && (arc[0][0].off < arc[0][0].on));
   COV_BATCH: cover property ($rose(batch_use[0]));

endmodule : pct_cam_timer

//--- testbench/pct_resolver_model.sv
/*
 Crank angle resolver model: presents a whole-degree angle to the cam timer.
 Assumes the bench either loads an angle or lets the crank turn one degree per clock.
*/
`timescale 1ns/100ps

module pct_resolver_model (
   input wire logic clk,
   input wire logic resetn,
   input wire logic load,
   input wire logic [8:0] load_val,
   input wire logic spin,
   output logic [8:0] angle_pin
);
   // Crank stands still unless told to turn; a stopped crank keeps its angle
   always_ff @(posedge clk) begin
      if (!resetn) begin
         angle_pin <= 9'h000;
      end else if (load) begin
         angle_pin <= load_val;
      end else if (spin) begin
         angle_pin <= (angle_pin == 9'h167) ? 9'h000 : angle_pin + 9'h001;
      end
   end
endmodule : pct_resolver_model

//--- testbench/pct_cam_timer_tb.sv
/*
 Self-checking bench of the cam timer: arcs, arc pool, clearing, timed dwell, batch masking.
 Assumes the strobe register port and the resolver model; the millisecond is shortened.
*/
`timescale 1ns/100ps
`include "pct_regs.svh"

module pct_cam_timer_tb;
   localparam int unsigned MS = 8;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic [15:0] cam_out;
   logic [8:0] angle_pin;
   logic load = 1'b0;
   logic [8:0] load_val = 9'h000;
   logic spin = 1'b0;
   int fail_count = 0;
   int num_checks = 0;
   int cyc = 0;
   logic [31:0] rv;
   logic [8:0] a_on, a_off, a;
   int n;

   always #12.5 clk = ~clk;

   pct_cam_timer #(.MS_CYCLES(MS)) dut_u (.clk(clk), .resetn(resetn), .angle_pin(angle_pin),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .cam_out(cam_out));
   pct_resolver_model res_u (.clk(clk), .resetn(resetn), .load(load), .load_val(load_val),
      .spin(spin), .angle_pin(angle_pin));

   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : results

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   // Hang guard well above the expected run length
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         fail_count++;
         results();
      end
   end

   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= ad;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr

   // Data stand only in the cycle after the read edge
   task automatic rd(input logic [7:0] ad, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= ad;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : rd

   task automatic ang(input logic [8:0] v);
      @(posedge clk);
      load_val <= v;
      load <= 1'b1;
      @(posedge clk);
      load <= 1'b0;
      repeat (5) @(posedge clk);
      #1;
   endtask : ang

   task automatic set_arc(input logic [3:0] ch, input logic [8:0] on, input logic [8:0] off);
      wr(`PCT_REG_SEL, {28'h0000_000, ch});
      wr(`PCT_REG_ANG, {7'h00, off, 7'h00, on});
   endtask : set_arc

   // Expected arc membership: on inclusive, off exclusive, wraps when off below on
   function automatic logic in_arc(input logic [8:0] x, input logic [8:0] on, input logic [8:0] off);
      if (on == off) return 1'b0;
      if (on < off) return (x >= on) && (x < off);
      return (x >= on) || (x < off);
   endfunction : in_arc

   initial begin
      void'($urandom(32'h8b9d));
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      rd(`PCT_REG_STATUS, rv);
      chk("status_reset", rv, 32'h0000_0000);
      chk("out_reset", {16'h0000, cam_out}, 32'h0000_0000);
      rd(8'h3C, rv);
      chk("unmapped", rv, 32'h0000_0000);
      // Plain and wrapping arcs, crank stopped inside them and on the off edge
      set_arc(4'h0, 9'h00A, 9'h014);
      set_arc(4'h1, 9'h15E, 9'h005);
      ang(9'h00F);
      chk("arc_in", {31'h0, cam_out[0]}, 32'h1);
      repeat (100) @(posedge clk);
      chk("arc_hold", {31'h0, cam_out[0]}, 32'h1);
      ang(9'h014);
      chk("arc_off_edge", {31'h0, cam_out[0]}, 32'h0);
      ang(9'h002);
      chk("arc_wrap", {31'h0, cam_out[1]}, 32'h1);
      // Random arcs and angles on channel 0
      for (int i = 0; i < 16; i++) begin
         a_on = 9'($urandom % 360);
         a_off = (i == 0) ? a_on : 9'($urandom % 360);
         a = (i == 1) ? a_on : 9'($urandom % 360);
         set_arc(4'h0, a_on, a_off);
         ang(a);
         chk("arc_rand", {31'h0, cam_out[0]}, {31'h0, in_arc(a, a_on, a_off)});
      end
      // Four arcs per channel, extra pool of six shared with a global channel
      wr(`PCT_REG_GLOBAL, 32'h0000_0008);
      wr(`PCT_REG_SEL, 32'h0000_0002);
      repeat (4) wr(`PCT_REG_CMD, 32'h0000_0001);
      wr(`PCT_REG_CMD, 32'h0000_0001);
      rd(`PCT_REG_CMD, rv);
      chk("arc_count4", {29'h0, rv[4:2]}, 32'h4);
      rd(`PCT_REG_STATUS, rv);
      chk("fifth_arc_refused", {31'h0, rv[16]}, 32'h1);
      wr(`PCT_REG_STATUS, 32'h0001_0000);
      wr(`PCT_REG_SEL, 32'h0000_0003);
      repeat (4) wr(`PCT_REG_CMD, 32'h0000_0001);
      rd(`PCT_REG_ANG, rv);
      chk("new_arc_zero", rv, 32'h0000_0000);
      rd(`PCT_REG_SEL, rv);
      chk("new_arc_sel", {30'h0, rv[5:4]}, 32'h3);
      wr(`PCT_REG_SEL, 32'h0000_0004);
      wr(`PCT_REG_CMD, 32'h0000_0001);
      rd(`PCT_REG_STATUS, rv);
      chk("pool_full", {16'h0, rv[16], 9'h0, rv[5:0]}, 32'h0000_0006);
      wr(`PCT_REG_CMD, 32'h0000_0001);
      rd(`PCT_REG_STATUS, rv);
      chk("pool_refused", {31'h0, rv[16]}, 32'h1);
      // Clearing a whole channel is the only way to drop arcs
      wr(`PCT_REG_SEL, 32'h0000_0002);
      wr(`PCT_REG_CMD, 32'h0000_0003);
      rd(`PCT_REG_CMD, rv);
      chk("clr_count", {29'h0, rv[4:2]}, 32'h0);
      rd(`PCT_REG_STATUS, rv);
      chk("clr_pool", {26'h0, rv[5:0]}, 32'h3);
      // Timed channels: four per tool, a fifth refused, dwell setting clamped
      wr(`PCT_REG_STATUS, 32'h0001_0000);
      for (int c = 9; c < 14; c++) begin
         set_arc(4'(c), 9'h064, 9'h000);
         wr(`PCT_REG_DWELL, 32'h0000_0002);
         wr(`PCT_REG_CMD, 32'h0000_0004);
      end
      rd(`PCT_REG_STATUS, rv);
      chk("timed_limit", {15'h0, rv[16], 11'h0, rv[12:8]}, 32'h0001_0004);
      rd(`PCT_REG_CMD, rv);
      chk("fifth_timed_mode", {31'h0, rv[0]}, 32'h0);
      wr(`PCT_REG_DWELL, 32'h0000_003F);
      rd(`PCT_REG_DWELL, rv);
      chk("dwell_clamp", {26'h0, rv[5:0]}, 32'h0000_0032);
      // Crossing the on angle starts a dwell of 20 ms that ends with the crank stopped
      ang(9'h063);
      ang(9'h065);
      chk("timed_on", {31'h0, cam_out[9]}, 32'h1);
      n = 0;
      while (cam_out[9] === 1'b1 && n < 400) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk("dwell_len", {31'h0, (n >= 19 * MS) && (n <= 20 * MS + 8)}, 32'h1);
      repeat (300) @(posedge clk);
      #1;
      chk("no_retrigger", {31'h0, cam_out[9]}, 32'h0);
      // Turning past the on angle again fires once more
      spin <= 1'b1;
      repeat (360) @(posedge clk);
      spin <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
      chk("retrigger", {31'h0, cam_out[9]}, 32'h1);
      // Batch counter one in use forces channel six off
      set_arc(4'h5, 9'h000, 9'h12C);
      ang(9'h096);
      chk("ch6_on", {31'h0, cam_out[5]}, 32'h1);
      rd(`PCT_REG_POS, rv);
      chk("pos", rv, 32'h0000_0096);
      @(posedge clk);
      #1;
      chk("rdata_idle", reg_rdata, 32'h0000_0000);
      wr(`PCT_REG_BATCH, 32'h0000_0001);
      repeat (3) @(posedge clk);
      #1;
      chk("ch6_forced", {31'h0, cam_out[5]}, 32'h0);
      rd(`PCT_REG_OUT, rv);
      // Channels 10 to 13 still timing, 14 inside its wrap arc, 6 forced off, 1 from its random arc
      chk("out_reg", rv, {16'h0000, 15'h1F00, in_arc(9'h096, a_on, a_off)});
      results();
   end
endmodule : pct_cam_timer_tb
